// File: include/mtp_pkg.sv
// Shared types and constants for the memory type policy block.
package mtp_pkg;

    // ==========================================
    // Memory type attribute carried with each access
    // ==========================================
    typedef enum logic [2:0] {
        strict_uncached_type    = 3'h0,
        cache_disabled_type     = 3'h1,
        write_combining_type    = 3'h2,
        coherent_combining_type = 3'h3,
        write_protect_type      = 3'h4,
        writethrough_type       = 3'h5,
        writeback_type          = 3'h6
    } mtp_mtype_t;

    // Access kinds from the pipeline; code 3 is illegal and handled as a non-store data read without the load-only pass and merge
    typedef enum logic [1:0] {
        acc_fetch = 2'h0,
        acc_load  = 2'h1,
        acc_store = 2'h2
    } mtp_kind_t;

    // Per-access sequencer, one-hot
    typedef enum logic [4:0] {
        st_idle  = 5'h01,
        st_drain = 5'h02,
        st_evict = 5'h04,
        st_snoop = 5'h08,
        st_done  = 5'h10
    } mtp_state_t;

    // ==========================================
    // Address geometry
    // ==========================================
    localparam int ADDR_W = 32;
    localparam int LINE_SHIFT = 6;
    localparam int PAGE_SHIFT = 12;
    localparam int PAGE_SIZE_KB = 4;
    localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
    localparam int LINE_W = ADDR_W - LINE_SHIFT;
    localparam logic [PAGE_W-1:0] PAGE_ONE = 20'h00001;
    localparam logic [LINE_SHIFT-1:0] LINE_ZERO = 6'h00;

    // ==========================================
    // Values after reset
    // ==========================================
    localparam logic RST_READY = 1'b1;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [PAGE_W-1:0] RST_PAGE = 20'h00000;
    localparam logic [LINE_W-1:0] RST_LINE = 26'h0000000;
    localparam logic [ADDR_W-1:0] RST_ADDR = 32'h00000000;

    // Types whose lines may live in the caches
    function automatic logic mtp_cacheable(input mtp_mtype_t t);
        mtp_cacheable = (t == write_protect_type) || (t == writethrough_type) || (t == writeback_type);
    endfunction

endpackage

// File: rtl/mtp_type_resolve.sv
// Effective memory type from the table type, conflicts and the global disable bit.
module mtp_type_resolve (
    input wire mtp_pkg::mtp_mtype_t page_type,
    input wire logic type_conflict,
    input wire logic global_cache_disable_bit,
    input wire logic caches_stale,
    output mtp_pkg::mtp_mtype_t eff_type
);
    import mtp_pkg::*;

    mtp_mtype_t base_type;

    // ==========================================
    // Legalise the incoming code
    // ==========================================
    // Unknown codes fall back to the safest, fully ordered type
    always_comb begin
        unique case (page_type)
            strict_uncached_type, cache_disabled_type, write_combining_type,
            coherent_combining_type, write_protect_type, writethrough_type,
            writeback_type: base_type = page_type;
            default: base_type = strict_uncached_type;
        endcase
    end

    // ==========================================
    // Inferred cache-disabled and strict uncached cases
    // ==========================================
    always_comb begin
        eff_type = base_type;
        if (type_conflict) begin
            eff_type = cache_disabled_type;
        end else if (global_cache_disable_bit && mtp_cacheable(base_type)) begin
            // Once flushed nothing can hit, so plain uncached is exact
            eff_type = caches_stale ? cache_disabled_type : strict_uncached_type;
        end
    end

endmodule

// File: rtl/mtp_policy.sv
// Per-access caching and ordering policy decided from the memory type.
//
// Functional notes
// - Strict uncached: never cached, never speculative, never write combined.
// - Strict uncached access waits until store and combining buffers drain.
// - Speculation-capable loads may pass non-conflicting strict uncached accesses.
// - Disable bit set with unflushed caches turns cacheable regions cache-disabled.
// - Conflicting page and range types infer the cache-disabled type.
// - Cache-disabled data hit: write back, invalidate, then go to memory.
// - Cache-disabled fetch: hits served from cache, misses never replace lines.
// - Cache-disabled write hitting instruction cache invalidates that line.
// - Write combining: uncached, speculative reads, writes merged in buffers.
// - Write combining reads merge within a line, never across a barrier.
// - Coherent combining: combine like write combining, snoop every cache.
// - Write protect: reads allocate; writes go to memory, hits invalidate.
// - Writethrough: reads allocate; writes hit update line, misses no allocate.
// - Writeback: read miss allocates a line, speculative reads allowed.
// - Writeback: writes mark lines modified, memory written only on writeback.
// - Combining buffers are separate from the ordinary store buffers.
// - Uncached fetch reads a naturally aligned block of at most one line.
// - Branch targets in uncached memory are fetched only non-speculatively.
// - Speculative sequential fetch never passes from cacheable into uncached.
// - Speculative sequential fetch crosses at most one 4KB page boundary.
module mtp_policy (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic acc_valid,
    input wire mtp_pkg::mtp_kind_t acc_kind,
    input wire logic [mtp_pkg::ADDR_W-1:0] acc_addr,
    input wire logic acc_spec,
    input wire logic acc_seq,
    input wire logic acc_branch_tgt,
    input wire logic acc_hit_dc,
    input wire logic acc_hit_ic,
    input wire logic acc_hit_sys,
    input wire mtp_pkg::mtp_mtype_t page_type,
    input wire logic type_conflict,
    input wire logic global_cache_disable_bit,
    input wire logic cache_inval_done,
    input wire logic barrier,
    input wire logic sb_empty,
    input wire logic wcb_empty,
    input wire logic evict_done,
    input wire logic snoop_done,
    output logic acc_ready_ff,
    output logic drain_req_ff,
    output logic evict_req_ff,
    output logic snoop_req_ff,
    output logic dec_valid_ff,
    output mtp_pkg::mtp_mtype_t dec_type_ff,
    output mtp_pkg::mtp_kind_t dec_kind_ff,
    output logic dec_refuse_ff,
    output logic dec_cacheable_ff,
    output logic dec_allocate_ff,
    output logic dec_spec_ok_ff,
    output logic dec_pass_uc_ok_ff,
    output logic dec_use_wcbuf_ff,
    output logic dec_store_buf_ff,
    output logic dec_read_merge_ff,
    output logic dec_line_update_ff,
    output logic dec_mark_mod_ff,
    output logic dec_line_inval_ff,
    output logic dec_ic_inval_ff,
    output logic dec_mem_write_ff,
    output logic dec_from_icache_ff,
    output logic dec_no_replace_ff,
    output logic [mtp_pkg::ADDR_W-1:0] dec_fetch_base_ff
);
    import mtp_pkg::*;

    mtp_mtype_t eff_type;
    mtp_state_t state_ff;
    mtp_state_t nxt_state;
    logic take, is_fetch, is_store, own_hit, cacheable_t, spec_t, combine_t;
    logic br_refuse, seq_refuse, page_refuse, spec_data_refuse, refuse_now, ok;
    logic need_drain, need_evict, need_snoop, wc_merge;
    logic [PAGE_W-1:0] cur_page;
    logic [LINE_W-1:0] cur_line;
    logic cd_bit_q_ff;
    logic stale_ff;
    logic [PAGE_W-1:0] anchor_page_ff;
    logic anchor_vld_ff;
    logic last_fetch_cach_ff;
    logic [LINE_W-1:0] wc_line_ff;
    logic wc_line_vld_ff;

    // ==========================================
    // Type resolution
    // ==========================================
    // resolved type attribute
    mtp_type_resolve u_resolve (
        .page_type(page_type),
        .type_conflict(type_conflict),
        .global_cache_disable_bit(global_cache_disable_bit),
        .caches_stale(stale_ff),
        .eff_type(eff_type)
    );

    // Stale-cache tracking; a rise in the same cycle as a flush wins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cd_bit_q_ff <= RST_FLAG;
            stale_ff <= RST_FLAG;
        end else begin
            cd_bit_q_ff <= global_cache_disable_bit;
            if (global_cache_disable_bit && !cd_bit_q_ff) begin
                stale_ff <= 1'b1;
            end else if (cache_inval_done) begin
                stale_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Access classification
    // ==========================================
    assign take = acc_valid && acc_ready_ff;
    assign is_fetch = (acc_kind == acc_fetch);
    assign is_store = (acc_kind == acc_store);
    assign own_hit = is_fetch ? acc_hit_ic : acc_hit_dc;
    assign cacheable_t = mtp_cacheable(eff_type);
    assign combine_t = (eff_type == write_combining_type) || (eff_type == coherent_combining_type);
    assign spec_t = cacheable_t || (eff_type == write_combining_type);
    assign cur_page = acc_addr[ADDR_W-1:PAGE_SHIFT];
    assign cur_line = acc_addr[ADDR_W-1:LINE_SHIFT];

    // Speculation limits on the fetch stream and on uncached data accesses
    // branch target refused
    assign br_refuse = is_fetch && acc_spec && acc_branch_tgt && !cacheable_t;
    assign seq_refuse = is_fetch && acc_spec && acc_seq && last_fetch_cach_ff && !cacheable_t;
    assign page_refuse = is_fetch && acc_spec && acc_seq && anchor_vld_ff
        && (cur_page != anchor_page_ff) && (cur_page != (anchor_page_ff + PAGE_ONE));
    assign spec_data_refuse = !is_fetch && acc_spec
        && ((eff_type == strict_uncached_type) || (eff_type == cache_disabled_type));
    assign refuse_now = br_refuse || seq_refuse || page_refuse || spec_data_refuse;
    assign ok = !refuse_now;

    assign need_drain = ok && (eff_type == strict_uncached_type);
    assign need_evict = ok && !is_fetch && (eff_type == cache_disabled_type) && (acc_hit_dc || acc_hit_sys);
    assign need_snoop = ok && (eff_type == coherent_combining_type);
    assign wc_merge = ok && (acc_kind == acc_load) && (eff_type == write_combining_type)
        && wc_line_vld_ff && (wc_line_ff == cur_line) && !barrier;

    // ==========================================
    // Sequencer
    // ==========================================
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_idle: begin
                if (take) begin
                    if (need_drain) begin
                        nxt_state = st_drain;
                    end else if (need_evict) begin
                        nxt_state = st_evict;
                    end else if (need_snoop) begin
                        nxt_state = st_snoop;
                    end else begin
                        nxt_state = st_done;
                    end
                end
            end
            st_drain: begin
                if (sb_empty && wcb_empty) begin
                    nxt_state = st_done;
                end
            end
            st_evict: begin
                if (evict_done) begin
                    nxt_state = st_done;
                end
            end
            st_snoop: begin
                if (snoop_done) begin
                    nxt_state = st_done;
                end
            end
            st_done: nxt_state = st_idle;
            // A corrupted one-hot code recovers to idle
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Handshake and side requests registered from the next state; dec_valid_ff from the current state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            acc_ready_ff <= RST_READY;
            drain_req_ff <= RST_FLAG;
            evict_req_ff <= RST_FLAG;
            snoop_req_ff <= RST_FLAG;
            dec_valid_ff <= RST_FLAG;
        end else begin
            acc_ready_ff <= (nxt_state == st_idle);
            drain_req_ff <= (nxt_state == st_drain);
            evict_req_ff <= (nxt_state == st_evict);
            snoop_req_ff <= (nxt_state == st_snoop);
            dec_valid_ff <= (state_ff == st_done);
        end
    end

    // ==========================================
    // Policy decision, captured at acceptance
    // ==========================================
    // Held until the next acceptance so the answer can be read late
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dec_type_ff <= strict_uncached_type;
            dec_kind_ff <= acc_fetch;
            dec_refuse_ff <= RST_FLAG;
            dec_cacheable_ff <= RST_FLAG;
            dec_allocate_ff <= RST_FLAG;
            dec_spec_ok_ff <= RST_FLAG;
            dec_pass_uc_ok_ff <= RST_FLAG;
            dec_use_wcbuf_ff <= RST_FLAG;
            dec_store_buf_ff <= RST_FLAG;
            dec_read_merge_ff <= RST_FLAG;
            dec_line_update_ff <= RST_FLAG;
            dec_mark_mod_ff <= RST_FLAG;
            dec_line_inval_ff <= RST_FLAG;
            dec_ic_inval_ff <= RST_FLAG;
            dec_mem_write_ff <= RST_FLAG;
            dec_from_icache_ff <= RST_FLAG;
            dec_no_replace_ff <= RST_FLAG;
            dec_fetch_base_ff <= RST_ADDR;
        end else if (take) begin
            dec_type_ff <= eff_type;
            dec_kind_ff <= acc_kind;
            dec_refuse_ff <= refuse_now;
            dec_cacheable_ff <= ok && (is_store ? (eff_type == writethrough_type
                || eff_type == writeback_type) : cacheable_t);
            // read miss allocates; write miss only for writeback
            dec_allocate_ff <= ok && !own_hit && (is_store ? (eff_type == writeback_type) : cacheable_t);
            dec_spec_ok_ff <= ok && !is_store && spec_t;
            dec_pass_uc_ok_ff <= ok && (acc_kind == acc_load) && spec_t;
            dec_use_wcbuf_ff <= ok && is_store && combine_t;
            dec_store_buf_ff <= ok && is_store && cacheable_t;
            dec_read_merge_ff <= wc_merge;
            dec_line_update_ff <= ok && is_store && own_hit
                && (eff_type == writethrough_type || eff_type == writeback_type);
            dec_mark_mod_ff <= ok && is_store && (eff_type == writeback_type);
            dec_line_inval_ff <= ok && is_store && own_hit && (eff_type == write_protect_type);
            dec_ic_inval_ff <= ok && is_store && (eff_type == cache_disabled_type) && acc_hit_ic;
            dec_mem_write_ff <= ok && is_store && (eff_type != writeback_type);
            dec_from_icache_ff <= ok && is_fetch && (eff_type == cache_disabled_type) && acc_hit_ic;
            dec_no_replace_ff <= ok && is_fetch && (eff_type == cache_disabled_type);
            dec_fetch_base_ff <= (is_fetch && !cacheable_t) ? {cur_line, LINE_ZERO} : acc_addr;
        end
    end

    // ==========================================
    // Fetch stream history
    // ==========================================
    // Anchor moves on demand or redirected fetches only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            anchor_page_ff <= RST_PAGE;
            anchor_vld_ff <= RST_FLAG;
            last_fetch_cach_ff <= RST_FLAG;
        end else if (take && is_fetch && ok) begin
            last_fetch_cach_ff <= cacheable_t;
            if (!acc_spec || !acc_seq) begin
                anchor_page_ff <= cur_page;
                anchor_vld_ff <= 1'b1;
            end
        end
    end

    // Open combining read line; a new read beats a barrier clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wc_line_ff <= RST_LINE;
            wc_line_vld_ff <= RST_FLAG;
        end else if (take && ok && (acc_kind == acc_load) && (eff_type == write_combining_type)) begin
            wc_line_ff <= cur_line;
            wc_line_vld_ff <= 1'b1;
        end else if (barrier) begin
            wc_line_vld_ff <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    chk_uc_no_cache: assert property (dec_valid_ff && dec_type_ff == strict_uncached_type |->
        !dec_cacheable_ff && !dec_spec_ok_ff && !dec_use_wcbuf_ff)
        else $error("strict uncached access was cached, speculative or combined");
    chk_uc_drain_req: assert property (take && need_drain |=> drain_req_ff && !dec_valid_ff)
        else $error("strict uncached access did not request a drain");
    chk_drain_hold: assert property (drain_req_ff && !(sb_empty && wcb_empty) |=>
        drain_req_ff && !dec_valid_ff)
        else $error("drain released before buffers emptied");
    chk_cd_evict: assert property (take && ok && !is_fetch && eff_type == cache_disabled_type
        && acc_hit_dc |=> evict_req_ff)
        else $error("cache-disabled hit did not request eviction");
    chk_cd_fetch: assert property (dec_valid_ff && dec_kind_ff == acc_fetch && !dec_refuse_ff
        && dec_type_ff == cache_disabled_type |-> !dec_allocate_ff && dec_no_replace_ff)
        else $error("cache-disabled fetch may replace a line");
    chk_ic_inval: assert property (take && ok && is_store && eff_type == cache_disabled_type
        && acc_hit_ic |=> dec_ic_inval_ff)
        else $error("instruction line not invalidated");
    chk_wp_write: assert property (dec_valid_ff && dec_kind_ff == acc_store
        && dec_type_ff == write_protect_type |-> dec_mem_write_ff && !dec_cacheable_ff
        && !dec_line_update_ff)
        else $error("write-protect write updated the cache");
    chk_wt_write: assert property (dec_valid_ff && dec_kind_ff == acc_store
        && dec_type_ff == writethrough_type |-> dec_mem_write_ff && !dec_allocate_ff
        && !dec_mark_mod_ff)
        else $error("writethrough write policy wrong");
    chk_wb_write: assert property (dec_valid_ff && dec_kind_ff == acc_store
        && dec_type_ff == writeback_type && !dec_refuse_ff |-> dec_mark_mod_ff
        && !dec_mem_write_ff)
        else $error("writeback write policy wrong");
    chk_wcp_snoop: assert property (take && need_snoop |=> snoop_req_ff ##1
        (snoop_req_ff || dec_valid_ff))
        else $error("coherent combining access did not snoop");
    chk_branch_spec: assert property (take && is_fetch && acc_spec && acc_branch_tgt
        && !cacheable_t |=> dec_refuse_ff ##1 dec_valid_ff)
        else $error("speculative uncached branch target accepted");
    chk_page_cross: assert property (take && page_refuse |=> dec_refuse_ff && $stable(anchor_page_ff))
        else $error("speculative fetch crossed two page boundaries");

    cov_uc_drain: cover property (drain_req_ff ##1 !drain_req_ff ##1 dec_valid_ff);
    cov_cd_evict: cover property (evict_req_ff ##1 dec_valid_ff);
    cov_wc_merge: cover property (dec_valid_ff && dec_read_merge_ff);
    cov_refuse: cover property (dec_valid_ff && dec_refuse_ff);

endmodule

// File: sim/mtp_mem_model.sv
// Behavioural memory system and remote caches facing the policy block.
module mtp_mem_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic drain_req_ff,
    input wire logic evict_req_ff,
    input wire logic snoop_req_ff,
    input wire logic slow,
    output logic sb_empty,
    output logic wcb_empty,
    output logic evict_done,
    output logic snoop_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busy_cnt_ff;
    logic busy;
    logic fin;
    // ==========================================
    // Service timing
    // ==========================================
    // Cycles spent on the open request; slow mode models a loaded memory
    assign busy = drain_req_ff || evict_req_ff || snoop_req_ff;
    assign fin = busy_cnt_ff >= (slow ? 4'h6 : 4'h1);
    always @(posedge clk_sys) begin
        if (!reset_n || !busy) begin
            busy_cnt_ff <= 4'h0;
        end else if (busy_cnt_ff != 4'hf) begin
            busy_cnt_ff <= busy_cnt_ff + 4'h1;
        end
    end
    // no read side effects here
    // In slow mode combining buffers empty later than the store buffer, so both must be awaited
    assign sb_empty = !drain_req_ff || busy_cnt_ff >= 4'h1;
    assign wcb_empty = !drain_req_ff || fin;
    assign evict_done = evict_req_ff && fin;
    assign snoop_done = snoop_req_ff && fin;
endmodule

// File: sim/mtp_policy_tb.sv
// Self-checking bench for the memory type policy block.
module mtp_policy_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mtp_pkg::*;
    logic clk_sys = 0, reset_n = 0, acc_valid = 0, acc_spec = 0, acc_seq = 0, acc_branch_tgt = 0, slow = 0;
    logic acc_hit_dc = 0, acc_hit_ic = 0, acc_hit_sys = 0, type_conflict = 0, global_cache_disable_bit = 0;
    logic cache_inval_done = 0, barrier = 0, sb_empty, wcb_empty, evict_done, snoop_done;
    logic acc_ready_ff, drain_req_ff, evict_req_ff, snoop_req_ff, dec_valid_ff, dec_refuse_ff, dec_cacheable_ff;
    logic dec_allocate_ff, dec_spec_ok_ff, dec_pass_uc_ok_ff, dec_use_wcbuf_ff, dec_store_buf_ff, dec_read_merge_ff;
    logic dec_line_update_ff, dec_mark_mod_ff, dec_line_inval_ff, dec_ic_inval_ff, dec_mem_write_ff;
    logic dec_from_icache_ff, dec_no_replace_ff;
    mtp_kind_t acc_kind = acc_load;
    mtp_kind_t dec_kind_ff;
    mtp_mtype_t page_type = writeback_type;
    mtp_mtype_t dec_type_ff;
    logic [31:0] acc_addr = 32'h0, dec_fetch_base_ff;
    logic [2:0] seen = 3'h0;
    int errors = 0, n_tests = 0;
    mtp_policy dut (.*);
    mtp_mem_model mem (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // Waits seen per access: drain, evict, snoop; cleared when an access is taken
    always @(posedge clk_sys)
        seen <= (acc_valid && acc_ready_ff) ? 3'h0 : seen | {drain_req_ff, evict_req_ff, snoop_req_ff};
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One access: kind, type code, address, {spec,seq,branch}, {dc,ic,sys} hits
    task automatic ac(input logic [1:0] k, input logic [2:0] t, input logic [31:0] a, input logic [2:0] f,
                      input logic [2:0] h);
        int i;
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_kind <= mtp_kind_t'(k);
        page_type <= mtp_mtype_t'(t);
        acc_addr <= a;
        {acc_spec, acc_seq, acc_branch_tgt} <= f;
        {acc_hit_dc, acc_hit_ic, acc_hit_sys} <= h;
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        for (i = 0; i < 40 && dec_valid_ff !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (i == 40) begin
            errors++;
            conclude();
        end
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    // Strict uncached: drain first, never cached, speculation refused
    task automatic t_uncached;
        ac(2'h1, 3'h0, 32'h1000, 3'h0, 3'h0);
        ck("uc_drain", seen[2], 1);
        ck("uc_cache", dec_cacheable_ff, 0);
        ck("uc_type", dec_type_ff, strict_uncached_type);
        ac(2'h1, 3'h0, 32'h1000, 3'h4, 3'h0);
        ck("uc_spec", dec_refuse_ff, 1);
        @(posedge clk_sys);
        slow <= 1'b1;
        ac(2'h2, 3'h0, 32'h1008, 3'h0, 3'h0);
        ck("uc_st_drain", seen[2], 1);
        ck("uc_wcbuf", dec_use_wcbuf_ff, 0);
    endtask
    // Cacheable types: allocation, line update and memory writes
    task automatic t_cacheable;
        ac(2'h1, 3'h6, 32'h2000, 3'h4, 3'h0);
        ck("wb_alloc", dec_allocate_ff, 1);
        ck("wb_spec", dec_spec_ok_ff, 1);
        ck("wb_pass", dec_pass_uc_ok_ff, 1);
        ac(2'h2, 3'h6, 32'h2040, 3'h0, 3'h4);
        ck("wb_mod", dec_mark_mod_ff, 1);
        ck("wb_mem", dec_mem_write_ff, 0);
        ck("wb_cache", dec_cacheable_ff, 1);
        ck("wb_sb", dec_store_buf_ff, 1);
        ck("wb_kind", dec_kind_ff, acc_store);
        ac(2'h2, 3'h6, 32'h2080, 3'h0, 3'h0);
        ck("wb_st_alloc", dec_allocate_ff, 1);
        ac(2'h2, 3'h5, 32'h2100, 3'h0, 3'h4);
        ck("wt_upd", dec_line_update_ff, 1);
        ck("wt_mod", dec_mark_mod_ff, 0);
        ck("wt_mem", dec_mem_write_ff, 1);
        ac(2'h2, 3'h5, 32'h2140, 3'h0, 3'h0);
        ck("wt_alloc", dec_allocate_ff, 0);
        ac(2'h2, 3'h4, 32'h2200, 3'h0, 3'h4);
        ck("wp_inval", dec_line_inval_ff, 1);
        ck("wp_upd", dec_line_update_ff, 0);
        ck("wp_mem", dec_mem_write_ff, 1);
        ac(2'h1, 3'h4, 32'h2240, 3'h0, 3'h0);
        ck("wp_alloc", dec_allocate_ff, 1);
    endtask
    // Combining types: separate buffers, merges cut by a barrier, snooping
    task automatic t_combining;
        ac(2'h2, 3'h2, 32'h3000, 3'h0, 3'h0);
        ck("wc_buf", dec_use_wcbuf_ff, 1);
        ck("wc_sb", dec_store_buf_ff, 0);
        ac(2'h1, 3'h2, 32'h3000, 3'h4, 3'h0);
        ck("wc_spec", dec_spec_ok_ff, 1);
        ac(2'h1, 3'h2, 32'h3010, 3'h0, 3'h0);
        ck("wc_merge", dec_read_merge_ff, 1);
        @(posedge clk_sys);
        barrier <= 1'b1;
        @(posedge clk_sys);
        barrier <= 1'b0;
        ac(2'h1, 3'h2, 32'h3020, 3'h0, 3'h0);
        ck("wc_barrier", dec_read_merge_ff, 0);
        ac(2'h2, 3'h3, 32'h3100, 3'h0, 3'h0);
        ck("wcp_snoop", seen[0], 1);
        ck("wcp_buf", dec_use_wcbuf_ff, 1);
    endtask
    // Cache-disabled: inferred types, eviction and instruction cache handling
    task automatic t_disabled;
        @(posedge clk_sys);
        type_conflict <= 1'b1;
        ac(2'h1, 3'h6, 32'h4000, 3'h0, 3'h4);
        ck("cd_conflict", dec_type_ff, cache_disabled_type);
        ck("cd_evict", seen[1], 1);
        @(posedge clk_sys);
        type_conflict <= 1'b0;
        ac(2'h2, 3'h1, 32'h4040, 3'h0, 3'h1);
        ck("cd_sys_evict", seen[1], 1);
        ac(2'h0, 3'h1, 32'h4080, 3'h0, 3'h2);
        ck("cd_ic_hit", dec_from_icache_ff, 1);
        ac(2'h0, 3'h1, 32'h40c0, 3'h0, 3'h0);
        ck("cd_no_repl", dec_no_replace_ff, 1);
        ac(2'h2, 3'h1, 32'h4100, 3'h0, 3'h2);
        ck("cd_ic_inval", dec_ic_inval_ff, 1);
        @(posedge clk_sys);
        global_cache_disable_bit <= 1'b1;
        ac(2'h1, 3'h6, 32'h4200, 3'h0, 3'h0);
        ck("gcd_stale", dec_type_ff, cache_disabled_type);
        @(posedge clk_sys);
        cache_inval_done <= 1'b1;
        @(posedge clk_sys);
        cache_inval_done <= 1'b0;
        ac(2'h1, 3'h6, 32'h4200, 3'h0, 3'h0);
        ck("gcd_flushed", dec_type_ff, strict_uncached_type);
        @(posedge clk_sys);
        global_cache_disable_bit <= 1'b0;
    endtask
    // Fetch limits: aligned block, branch targets, type change, page reach
    task automatic t_fetch;
        ac(2'h0, 3'h0, 32'h5abc, 3'h0, 3'h0);
        ck("fetch_base", dec_fetch_base_ff, 32'h5a80);
        ac(2'h0, 3'h0, 32'h5b00, 3'h5, 3'h0);
        ck("br_refuse", dec_refuse_ff, 1);
        ac(2'h0, 3'h6, 32'h6000, 3'h0, 3'h0);
        ac(2'h0, 3'h0, 32'h6040, 3'h6, 3'h0);
        ck("seq_uc", dec_refuse_ff, 1);
        ac(2'h0, 3'h6, 32'h7000, 3'h6, 3'h0);
        ck("page_next", dec_refuse_ff, 0);
        ac(2'h0, 3'h6, 32'h8000, 3'h6, 3'h0);
        ck("page_far", dec_refuse_ff, 1);
    endtask
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;
        ck("rst_ready", acc_ready_ff, RST_READY);
        ck("rst_drain", drain_req_ff, 0);
        t_uncached();
        t_cacheable();
        t_combining();
        t_disabled();
        t_fetch();
        conclude();
    end
endmodule
